// file: core/slo_consts.svh
`ifndef SLO_CONSTS_SVH
`define SLO_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address = page base + 4 * index)
// ----------------------------------------------------------------
`define SLO_IDX_DEEMPH_L1 8'h12
`define SLO_IDX_DEEMPH_L0 8'h13
`define SLO_IDX_DEEMPH_L2 8'h14
`define SLO_IDX_DEEMPH_L3 8'h15
`define SLO_IDX_SER_MULT 8'h16
`define SLO_IDX_OVR_ROUTE 8'h1A
`define SLO_IDX_SWING_OVR 8'h1B
`define SLO_IDX_LANE_MODE 8'h01
`define SLO_IDX_LANE_MERGE 8'h16
`define SLO_IDX_MAP_LOW 8'h31
`define SLO_IDX_MAP_HIGH 8'h32
`define SLO_IDX_STATUS 8'h00
// ----------------------------------------------------------------
// Page bases (byte address bits 11:10)
// ----------------------------------------------------------------
`define SLO_PAGE_ANALOG 2'h0
`define SLO_PAGE_DIGITAL 2'h1
`define SLO_PAGE_STATUS 2'h2
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SLO_POS_DEEMPH 2
`define SLO_POS_MERGE 5
`define SLO_POS_ROUTE 1
`define SLO_POS_SWING 5
`define SLO_POS_OVR_EN 3
`define SLO_POS_FILTER 3
// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define SLO_RST_DEEMPH 6'h00
`define SLO_RST_MULT 2'h0
`define SLO_RST_SWING 3'h0
`define SLO_RST_MAP 8'h00
`define SLO_RST_MODE 3'h1
`define SLO_RST_FILTER 3'h0
`define SLO_MULT_20X 2'h0
`define SLO_MULT_40X 2'h2
`define SLO_MODE_FOUR 3'h1
`define SLO_MODE_TWO 3'h2
`define SLO_MODE_TWO_ONLY 3'h4
`define SLO_FILT_DEC4 3'h4
`define SLO_FILT_DEC2 3'h6
`define SLO_FILT_DEC4_IQ 3'h7
`define SLO_MERGE_FIXED 2'h2
`define SLO_LANES_FOUR 4'hF
`define SLO_LANES_TWO 4'h3
`define SLO_LANES_ONE 4'h1
`define SLO_RESP_OKAY 2'h0
`define SLO_RESP_SLVERR 2'h2

`endif

// file: core/slo_pkg.sv
package slo_pkg;
  // Lane configuration handed to the serializer and driver
  typedef struct packed {
    logic [3:0][5:0] deemph;  // Lane 3..0 de-emphasis levels
    logic [2:0] swing;        // Output amplitude select
    logic [1:0] mult;         // Serializer multiplier select
    logic [3:0] lane_en;      // Active output lanes
    logic merge;              // Both channels on one lane
    logic [15:0] map;         // Stream to lane map, high:low
    logic map_bad;            // Map held outside its modes
    logic mismatch;           // Multiplier disagrees with mode
  } slo_cfg_t;
endpackage

// file: core/slo_top.sv
`include "slo_consts.svh"

// Overview of operation
// - Merge plus decimate-by-4 puts both channels on one lane
// - Merge cleared gives each channel its lane
// - Two eight-bit stream-to-lane map registers
// - Six-bit de-emphasis level per lane
// - Multiplier code 00 is 20X, 10 is 40X
// - Route bit needs override enable for pin
// - Override enable with route bit puts overrange flag on pin
// - Three-bit amplitude select for all lanes
// - Lane-count mode 001 four lanes, 010 two
module slo_top (
  input wire logic aclk,                // System clock
  input wire logic aresetn,             // Synchronous reset
  input wire logic ce,                  // Clock enable
  input wire logic [11:0] awaddr,       // Write address
  input wire logic awvalid,             // Write address valid
  output logic awready,                 // Write address ready
  input wire logic [31:0] wdata,        // Write data
  input wire logic [3:0] wstrb,         // Write strobes
  input wire logic wvalid,              // Write data valid
  output logic wready,                  // Write data ready
  output logic [1:0] bresp,             // Write response
  output logic bvalid,                  // Write response valid
  input wire logic bready,              // Write response ready
  input wire logic [11:0] araddr,       // Read address
  input wire logic arvalid,             // Read address valid
  output logic arready,                 // Read address ready
  output logic [31:0] rdata,            // Read data
  output logic [1:0] rresp,             // Read response
  output logic rvalid,                  // Read data valid
  input wire logic rready,              // Read data ready
  input wire logic fast_overrange_flag, // Channel A overrange
  input wire logic powerdown_pin_in,    // Normal power-down level
  output logic powerdown_pin_out,       // Level driven on pin
  output slo_pkg::slo_cfg_t cfg         // Lane configuration
);
  import slo_pkg::*;

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  logic [3:0][5:0] deemph_q;
  logic [1:0] mult_q;
  logic route_q;
  logic ovr_en_q;
  logic [2:0] swing_q;
  logic merge_q;
  logic [7:0] map_lo_q;
  logic [7:0] map_hi_q;
  logic [2:0] filter_q;
  logic [2:0] mode_q;

  // ----------------------------------------------------------------
  // Bus handshake state
  // ----------------------------------------------------------------
  logic [11:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane0_q;
  logic aw_full_q;
  logic w_full_q;
  slo_cfg_t cfg_d;

  // Write completes once both halves are held and no answer pends
  wire do_wr = ce & aw_full_q & w_full_q & ~bvalid;
  wire aw_hs = ce & awvalid & awready;
  wire w_hs = ce & wvalid & wready;
  wire b_hs = ce & bvalid & bready;
  wire ar_hs = ce & arvalid & arready;
  wire r_hs = ce & rvalid & rready;

  // Write decode
  wire [1:0] wpg = aw_addr_q[11:10];
  wire [7:0] widx = aw_addr_q[9:2];
  wire wan = wpg == `SLO_PAGE_ANALOG;
  wire wdg = wpg == `SLO_PAGE_DIGITAL;
  wire wr_en = do_wr & w_lane0_q;
  wire wr_l1 = wr_en & wan & (widx == `SLO_IDX_DEEMPH_L1);
  wire wr_l0 = wr_en & wan & (widx == `SLO_IDX_DEEMPH_L0);
  wire wr_l2 = wr_en & wan & (widx == `SLO_IDX_DEEMPH_L2);
  wire wr_l3 = wr_en & wan & (widx == `SLO_IDX_DEEMPH_L3);
  wire wr_mult = wr_en & wan & (widx == `SLO_IDX_SER_MULT);
  wire wr_route = wr_en & wan & (widx == `SLO_IDX_OVR_ROUTE);
  wire wr_swing = wr_en & wan & (widx == `SLO_IDX_SWING_OVR);
  wire wr_mode = wr_en & wdg & (widx == `SLO_IDX_LANE_MODE);
  wire wr_merge = wr_en & wdg & (widx == `SLO_IDX_LANE_MERGE);
  wire wr_mlo = wr_en & wdg & (widx == `SLO_IDX_MAP_LOW);
  wire wr_mhi = wr_en & wdg & (widx == `SLO_IDX_MAP_HIGH);
  wire wr_hit = wr_l1 | wr_l0 | wr_l2 | wr_l3 | wr_mult | wr_route
              | wr_swing | wr_mode | wr_merge | wr_mlo | wr_mhi;
  wire [7:0] wb = w_byte_q;

  // Read decode
  wire [1:0] rpg = araddr[11:10];
  wire [7:0] ridx = araddr[9:2];
  wire ran = rpg == `SLO_PAGE_ANALOG;
  wire rdg = rpg == `SLO_PAGE_DIGITAL;
  wire rst_hit = (rpg == `SLO_PAGE_STATUS) & (ridx == `SLO_IDX_STATUS);
  wire rh_l1 = ran & (ridx == `SLO_IDX_DEEMPH_L1);
  wire rh_l0 = ran & (ridx == `SLO_IDX_DEEMPH_L0);
  wire rh_l2 = ran & (ridx == `SLO_IDX_DEEMPH_L2);
  wire rh_l3 = ran & (ridx == `SLO_IDX_DEEMPH_L3);
  wire rh_mult = ran & (ridx == `SLO_IDX_SER_MULT);
  wire rh_route = ran & (ridx == `SLO_IDX_OVR_ROUTE);
  wire rh_swing = ran & (ridx == `SLO_IDX_SWING_OVR);
  wire rh_mode = rdg & (ridx == `SLO_IDX_LANE_MODE);
  wire rh_merge = rdg & (ridx == `SLO_IDX_LANE_MERGE);
  wire rh_mlo = rdg & (ridx == `SLO_IDX_MAP_LOW);
  wire rh_mhi = rdg & (ridx == `SLO_IDX_MAP_HIGH);
  wire rd_hit = rh_l1 | rh_l0 | rh_l2 | rh_l3 | rh_mult | rh_route
              | rh_swing | rh_mode | rh_merge | rh_mlo | rh_mhi | rst_hit;

  // Read data; reserved bits read as their fixed values
  wire [7:0] rd_byte =
      rh_l1 ? {deemph_q[1], 2'h0} :
      rh_l0 ? {deemph_q[0], 2'h0} :
      rh_l2 ? {deemph_q[2], 2'h0} :
      rh_l3 ? {deemph_q[3], 2'h0} :
      rh_mult ? {6'h00, mult_q} :
      rh_route ? {6'h00, route_q, 1'b0} :
      rh_swing ? {swing_q, 1'b0, ovr_en_q, 3'h0} :
      rh_mode ? {2'h0, filter_q, mode_q} :
      rh_merge ? {`SLO_MERGE_FIXED, merge_q, 5'h00} :
      rh_mlo ? map_lo_q :
      rh_mhi ? map_hi_q :
      rst_hit ? {4'h0, cfg.lane_en} & 8'h0F | {cfg.mismatch, cfg.map_bad,
                cfg.merge, 5'h00} :
      8'h00;

  // ----------------------------------------------------------------
  // Lane configuration logic
  // ----------------------------------------------------------------
  wire dec4 = (filter_q == `SLO_FILT_DEC4) | (filter_q == `SLO_FILT_DEC4_IQ);
  wire dec2 = filter_q == `SLO_FILT_DEC2;
  wire merge_on = merge_q & dec4;
  // Four-lane mode pairs with 20X, two-lane modes with 40X
  wire mode_four = mode_q == `SLO_MODE_FOUR;
  wire mode_two = (mode_q == `SLO_MODE_TWO) | (mode_q == `SLO_MODE_TWO_ONLY);
  wire mult_ok = (mode_four & (mult_q == `SLO_MULT_20X))
               | (mode_two & (mult_q == `SLO_MULT_40X));
  // Map only steers lanes in decimating modes; zero keeps natural order
  wire map_set = (map_lo_q != `SLO_RST_MAP) | (map_hi_q != `SLO_RST_MAP);
  wire map_use = (dec2 | dec4) & map_set;
  wire [3:0] lanes =
      merge_on ? `SLO_LANES_ONE :
      mode_four ? `SLO_LANES_FOUR :
      `SLO_LANES_TWO;
  // Pin is handed over only when both route and enable are set
  wire pin_ovr = route_q & ovr_en_q;

  // Next configuration word
  always_comb
  begin
    cfg_d = cfg;
    cfg_d.deemph = deemph_q;
    cfg_d.swing = swing_q;
    cfg_d.mult = mult_q;
    cfg_d.lane_en = lanes;
    cfg_d.merge = merge_on;
    cfg_d.map = map_use ? {map_hi_q, map_lo_q} : 16'h0000;
    cfg_d.map_bad = map_set & ~(dec2 | dec4);
    cfg_d.mismatch = ~mult_ok;
  end

  // ----------------------------------------------------------------
  // Register writes; reserved bits are never stored
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      deemph_q <= {4{`SLO_RST_DEEMPH}};
      mult_q <= `SLO_RST_MULT;
      route_q <= 1'b0;
      ovr_en_q <= 1'b0;
      swing_q <= `SLO_RST_SWING;
      merge_q <= 1'b0;
      map_lo_q <= `SLO_RST_MAP;
      map_hi_q <= `SLO_RST_MAP;
      filter_q <= `SLO_RST_FILTER;
      mode_q <= `SLO_RST_MODE;
    end
    else
    begin
      if (wr_l1) deemph_q[1] <= wb[7:`SLO_POS_DEEMPH];
      if (wr_l0) deemph_q[0] <= wb[7:`SLO_POS_DEEMPH];
      if (wr_l2) deemph_q[2] <= wb[7:`SLO_POS_DEEMPH];
      if (wr_l3) deemph_q[3] <= wb[7:`SLO_POS_DEEMPH];
      if (wr_mult) mult_q <= wb[1:0];
      if (wr_route) route_q <= wb[`SLO_POS_ROUTE];
      if (wr_swing) swing_q <= wb[7:`SLO_POS_SWING];
      if (wr_swing) ovr_en_q <= wb[`SLO_POS_OVR_EN];
      if (wr_mode) filter_q <= wb[5:`SLO_POS_FILTER];
      if (wr_mode) mode_q <= wb[2:0];
      if (wr_merge) merge_q <= wb[`SLO_POS_MERGE];
      if (wr_mlo) map_lo_q <= wb;
      if (wr_mhi) map_hi_q <= wb;
    end
  end

  // Outputs registered so the analog side sees clean levels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg <= '0;
      powerdown_pin_out <= 1'b0;
    end
    else if (ce)
    begin
      cfg <= cfg_d;
      powerdown_pin_out <= pin_ovr ? fast_overrange_flag : powerdown_pin_in;
    end
  end

  // ----------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_byte_q <= 8'h00;
      w_lane0_q <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `SLO_RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= awaddr;
        awready <= 1'b0;
      end
      if (w_hs)
      begin
        w_full_q <= 1'b1;
        w_byte_q <= wdata[7:0];
        w_lane0_q <= wstrb[0];
        wready <= 1'b0;
      end
      if (do_wr)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (wr_hit | ~w_lane0_q) & (wan | wdg) ? `SLO_RESP_OKAY
                                                     : `SLO_RESP_SLVERR;
      end
      if (b_hs)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel: data one cycle after the address is taken
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `SLO_RESP_OKAY;
    end
    else
    begin
      if (ar_hs)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_byte};
        rresp <= rd_hit ? `SLO_RESP_OKAY : `SLO_RESP_SLVERR;
      end
      if (r_hs)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  merge_one_lane_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && merge_q && dec4 |=> cfg.lane_en == `SLO_LANES_ONE && cfg.merge)
    else $error("merge did not select one lane");
  lane_per_chan_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !merge_q |=> !cfg.merge && cfg.lane_en != `SLO_LANES_ONE)
    else $error("lane merged while bit clear");
  map_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_mlo |=> map_lo_q == $past(w_byte_q))
    else $error("map low not stored");
  map_normal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !map_set |=> cfg.map == 16'h0000)
    else $error("reset map changed lane order");
  deemph_lane_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_l2 ##1 ce |=> cfg.deemph[2] == $past(w_byte_q, 2) >> 2)
    else $error("de-emphasis lane 2 wrong");
  mult_check_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mode_four && mult_q == `SLO_MULT_40X |=> cfg.mismatch)
    else $error("multiplier mismatch missed");
  pin_normal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !(route_q && ovr_en_q) |=> powerdown_pin_out == $past(powerdown_pin_in))
    else $error("pin not in normal function");
  pin_override_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && route_q && ovr_en_q |=> powerdown_pin_out == $past(fast_overrange_flag))
    else $error("overrange not on pin");
  swing_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce |=> cfg.swing == $past(swing_q))
    else $error("swing not applied");
  mode_lanes_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mode_four && !merge_on |=> cfg.lane_en == `SLO_LANES_FOUR)
    else $error("four-lane mode not applied");
endmodule

// file: dv/slo_fast_overrange_flag_src.sv
// ----------------------------------------------------------------
// Board side of the power-down pin and the overrange flag
// ----------------------------------------------------------------
module slo_fast_overrange_flag_src (
  input wire logic aclk,            // System clock
  input wire logic aresetn,         // Synchronous reset
  output logic fast_overrange_flag, // Channel A overrange level
  output logic powerdown_pin_in     // Normal power-down level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_q;

  // The flag moves every cycle and the pin level every second cycle, so a stale pin selection cannot hide
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= 2'h0;
    else
      cnt_q <= cnt_q + 2'h1;
  end

  // Flag and pin differ in half the cycles
  assign fast_overrange_flag = cnt_q[0];
  assign powerdown_pin_in = cnt_q[1];
endmodule

// file: dv/serial_lane_output_config_test.sv
`include "slo_consts.svh"

module serial_lane_output_config_test;
  import slo_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, ovr_flag, pin_in, pin_out;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  slo_cfg_t cfg, e;
  int error_cnt = 0;
  int checked = 0;
  localparam logic [1:0] OK = `SLO_RESP_OKAY;
  localparam logic [1:0] ERR = `SLO_RESP_SLVERR;
  localparam logic [1:0] AN = `SLO_PAGE_ANALOG;
  localparam logic [1:0] DG = `SLO_PAGE_DIGITAL;

  slo_top u_slo_top (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .fast_overrange_flag(ovr_flag), .powerdown_pin_in(pin_in),
    .powerdown_pin_out(pin_out), .cfg(cfg));

  slo_fast_overrange_flag_src u_slo_fast_overrange_flag_src (.aclk(aclk), .aresetn(aresetn),
    .fast_overrange_flag(ovr_flag), .powerdown_pin_in(pin_in));

  // Free-running 100 ns clock
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task close_out;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task ccfg;
    check(64'(cfg), 64'(e));
  endtask

  function automatic logic [11:0] ad(input logic [1:0] p, input logic [7:0] i);
    return {p, i, 2'h0};
  endfunction

  // Each valid drops at its own handshake; the spare edge at the end keeps
  // two tasks from driving one signal in the same time step
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      // Nothing is taken while the clock enable is low
      if (awready === 1'b1 && ce === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1 && ce === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 20);
    check(64'({bvalid, bresp}), 64'({1'b1, er}));
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1 && ce === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 20);
    check(64'({rvalid, rresp, rdata}), 64'({1'b1, er, 24'h000000, d}));
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] idx [7] = '{`SLO_IDX_DEEMPH_L1, `SLO_IDX_DEEMPH_L0, `SLO_IDX_DEEMPH_L2,
      `SLO_IDX_DEEMPH_L3, `SLO_IDX_SER_MULT, `SLO_IDX_OVR_ROUTE, `SLO_IDX_SWING_OVR};
    foreach (idx[i])
      rd(ad(AN, idx[i]), 8'h00, OK);
    rd(ad(DG, `SLO_IDX_MAP_LOW), 8'h00, OK);
    rd(ad(DG, `SLO_IDX_MAP_HIGH), 8'h00, OK);
    rd(ad(DG, `SLO_IDX_LANE_MERGE), 8'h80, OK);
    rd(ad(DG, `SLO_IDX_LANE_MODE), {5'h00, `SLO_MODE_FOUR}, OK);
    rd(ad(`SLO_PAGE_STATUS, `SLO_IDX_STATUS), {4'h0, `SLO_LANES_FOUR}, OK);
    ccfg();
  endtask

  // Registers sit in lane order 1, 0, 2, 3; seven level codes from 00 to 3F are used, setting each level bit in turn
  task automatic t_deemph;
    logic [7:0] idx [4] = '{`SLO_IDX_DEEMPH_L1, `SLO_IDX_DEEMPH_L0, `SLO_IDX_DEEMPH_L2,
      `SLO_IDX_DEEMPH_L3};
    int lane [4] = '{1, 0, 2, 3};
    logic [5:0] code [7] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h1F, 6'h3F};
    for (int k = 0; k < 7; k++)
    begin
      wr(ad(AN, idx[k % 4]), {code[k], 2'h0}, OK);
      rd(ad(AN, idx[k % 4]), {code[k], 2'h0}, OK);
      e.deemph[lane[k % 4]] = code[k];
    end
    ccfg();
  endtask

  // First two pairs disagree, the rest agree; the two-lane-only mode is covered too
  task automatic t_mode;
    logic [2:0] md [5] = '{`SLO_MODE_FOUR, `SLO_MODE_TWO, `SLO_MODE_TWO, `SLO_MODE_TWO_ONLY,
      `SLO_MODE_FOUR};
    logic [1:0] ml [5] = '{`SLO_MULT_40X, `SLO_MULT_20X, `SLO_MULT_40X, `SLO_MULT_40X,
      `SLO_MULT_20X};
    for (int k = 0; k < 5; k++)
    begin
      wr(ad(DG, `SLO_IDX_LANE_MODE), {5'h00, md[k]}, OK);
      wr(ad(AN, `SLO_IDX_SER_MULT), {6'h00, ml[k]}, OK);
      rd(ad(AN, `SLO_IDX_SER_MULT), {6'h00, ml[k]}, OK);
      e.mult = ml[k];
      e.lane_en = (k >= 1 && k <= 3) ? `SLO_LANES_TWO : `SLO_LANES_FOUR;
      e.mismatch = (k < 2);
      ccfg();
      rd(ad(`SLO_PAGE_STATUS, `SLO_IDX_STATUS), {e.mismatch, 3'h0, e.lane_en}, OK);
    end
  endtask

  // Merge only counts under the two decimate-by-4 filters
  task automatic t_merge;
    logic [2:0] fl [4] = '{3'h0, `SLO_FILT_DEC4, `SLO_FILT_DEC4_IQ, `SLO_FILT_DEC2};
    wr(ad(DG, `SLO_IDX_LANE_MERGE), 8'hA0, OK);
    rd(ad(DG, `SLO_IDX_LANE_MERGE), 8'hA0, OK);
    for (int k = 0; k < 4; k++)
    begin
      wr(ad(DG, `SLO_IDX_LANE_MODE), {2'h0, fl[k], `SLO_MODE_FOUR}, OK);
      e.merge = (k == 1 || k == 2);
      e.lane_en = e.merge ? `SLO_LANES_ONE : `SLO_LANES_FOUR;
      ccfg();
    end
    wr(ad(DG, `SLO_IDX_LANE_MERGE), 8'h80, OK);
    e.merge = 1'b0;
    e.lane_en = `SLO_LANES_FOUR;
    ccfg();
  endtask

  task automatic t_map;
    wr(ad(DG, `SLO_IDX_LANE_MODE), {5'h00, `SLO_MODE_FOUR}, OK);
    wr(ad(DG, `SLO_IDX_MAP_LOW), 8'h5A, OK);
    wr(ad(DG, `SLO_IDX_MAP_HIGH), 8'hC3, OK);
    rd(ad(DG, `SLO_IDX_MAP_LOW), 8'h5A, OK);
    rd(ad(DG, `SLO_IDX_MAP_HIGH), 8'hC3, OK);
    e.map_bad = 1'b1;
    ccfg();
    rd(ad(`SLO_PAGE_STATUS, `SLO_IDX_STATUS), 8'h4F, OK);
    wr(ad(DG, `SLO_IDX_LANE_MODE), {2'h0, `SLO_FILT_DEC2, `SLO_MODE_FOUR}, OK);
    e.map_bad = 1'b0;
    e.map = 16'hC35A;
    ccfg();
    wr(ad(DG, `SLO_IDX_MAP_LOW), 8'h00, OK);
    wr(ad(DG, `SLO_IDX_MAP_HIGH), 8'h00, OK);
    e.map = 16'h0000;
    ccfg();
  endtask

  // Pin compared every cycle against the levels the design saw one edge earlier
  task automatic t_pin;
    logic [2:0] sw [4] = '{3'h0, 3'h4, 3'h3, 3'h7};
    logic sel;
    for (int k = 0; k < 4; k++)
    begin
      wr(ad(AN, `SLO_IDX_OVR_ROUTE), {6'h00, k[0], 1'h0}, OK);
      wr(ad(AN, `SLO_IDX_SWING_OVR), {sw[k], 1'h0, k[1], 3'h0}, OK);
      rd(ad(AN, `SLO_IDX_SWING_OVR), {sw[k], 1'h0, k[1], 3'h0}, OK);
      e.swing = sw[k];
      ccfg();
      @(posedge aclk);
      sel = (k == 3) ? ovr_flag : pin_in;
      repeat (4)
      begin
        @(posedge aclk);
        check(64'(pin_out), 64'(sel));
        sel = (k == 3) ? ovr_flag : pin_in;
      end
    end
  endtask

  // Unmapped places answer with an error and change nothing
  task automatic t_bad;
    logic [11:0] a [2] = '{12'hC00, 12'h0FC};
    foreach (a[i])
    begin
      wr(a[i], 8'hFF, ERR);
      rd(a[i], 8'h00, ERR);
    end
    ccfg();
    // Low byte strobe clear: accepted but nothing stored
    wstrb <= 4'hE;
    wr(ad(AN, `SLO_IDX_DEEMPH_L1), 8'hFC, OK);
    wstrb <= 4'hF;
    ccfg();
  endtask

  // Clock enable low freezes pin, answers and config while a write waits
  task automatic t_hold;
    logic p;
    ce <= 1'b0;
    @(posedge aclk);
    p = pin_out;
    fork
      wr(ad(AN, `SLO_IDX_SWING_OVR), 8'h80, OK);
      begin
        repeat (4)
        begin
          @(posedge aclk);
          check(64'({pin_out, bvalid}), 64'({p, 1'b0}));
          ccfg();
        end
        ce <= 1'b1;
      end
    join
    e.swing = 3'h4;
    ccfg();
  endtask

  // Reset again in mid-run; everything returns to its reset state
  task automatic t_rerun;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    e = '0;
    e.lane_en = `SLO_LANES_FOUR;
    t_reset();
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    aresetn = 1'b0;
    ce = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    e = '0;
    e.lane_en = `SLO_LANES_FOUR;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_deemph();
    t_mode();
    t_merge();
    t_map();
    t_pin();
    t_hold();
    t_bad();
    t_rerun();
    close_out();
  end

  // A few hundred transfers fit easily in this span
  initial
  begin
    #(100 * 20000);
    error_cnt++;
    close_out();
  end
endmodule
